// ===== bench/acrt_host.sv
// Host controller model: drives the control pins, times the replies and reads the serial word.
`timescale 1ns/100ps
`include "acrt_consts.svh"
module acrt_host #(
    parameter int DATA_W = 16
) (
    // Clock.
    input wire logic ref_clk,
    // Device outputs.
    input wire logic busy,
    input wire logic [DATA_W-1:0] data_bus,
    input wire acrt_pkg::acrt_serial_t serial_port,
    // Device control pins.
    output acrt_pkg::acrt_pins_t pins
);
    import acrt_pkg::*;
    int brise, bfall, dvalid, sync_at, sfall, clk1, clk2, nclk;
    logic [DATA_W-1:0] word;

    initial pins = `ACRT_PINS_RST;

    ////////////////////////////////////////////////////////////////////////////////
    // One conversion; all times are in cycles from the start pin falling.
    task automatic convert(input logic sel, input logic rac, input logic [1:0] div, input int abort_at);
        logic [DATA_W-1:0] last;
        logic sy;
        logic sc;
        logic bz;
        int k;
        brise = -1;
        bfall = -1;
        dvalid = -1;
        sync_at = -1;
        sfall = -1;
        clk1 = -1;
        clk2 = -1;
        nclk = 0;
        pins.serial_parallel_select = sel;
        pins.read_after_convert = rac;
        pins.serial_clock_divider = div;
        // Mode pins settle through the synchroniser before the start edge.
        repeat (4) @(posedge ref_clk);
        #1;
        pins.convert_start_n = 1'b0;
        last = data_bus;
        sy = 1'b0;
        sc = 1'b0;
        bz = 1'b0;
        for (k = 0; k < 3000; k++)
        begin
            if (k == 4) pins.convert_start_n = 1'b1;
            if (k == abort_at) pins.conversion_reset = 1'b1;
            if (k == abort_at + 4) pins.conversion_reset = 1'b0;
            if (busy && !bz) brise = k;
            if (!busy && bz) bfall = k;
            if (data_bus !== last) dvalid = k;
            if (serial_port.frame_sync && !sy) sync_at = k;
            if (!serial_port.frame_sync && sy) sfall = k;
            if (serial_port.serial_data_clock && !sc)
            begin
                if (nclk == 0) clk1 = k;
                if (nclk == 1) clk2 = k;
                nclk++;
                word = {word[DATA_W-2:0], serial_port.serial_data_out};
            end
            bz = busy;
            sy = serial_port.frame_sync;
            sc = serial_port.serial_data_clock;
            last = data_bus;
            if (k > 8 && !busy && !sy && bfall >= 0) break;
            @(posedge ref_clk);
            #1;
        end
        // The loop may end on busy falling while an abort is still held, so let go of it here.
        pins.conversion_reset = 1'b0;
        // Keep starts at least 4 us apart.
        if (k < 800) repeat (800 - k) @(posedge ref_clk);
        #1;
    endtask
endmodule // acrt_host

// ===== bench/acrt_top_tb.sv
// Self-checking bench for the conversion and readout sequencer.
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("Error %0t: got %0h expected %0h", $time, (a), (b)); end end
module acrt_top_tb;
    import acrt_pkg::*;
    typedef struct {logic sel; logic rac; logic [1:0] div; logic [15:0] res; logic [15:0] exp;} acrt_row_t;
    logic ref_clk;
    logic sys_rst;
    logic clk_en;
    logic [15:0] core_result;
    logic busy;
    logic [15:0] data_bus;
    logic data_bus_oe;
    acrt_pins_t pins;
    acrt_serial_t serial_port;
    int n_fail;
    int total_checks;
    logic [15:0] held;
    acrt_row_t rows[9] = '{
        '{1'b0, 1'b0, 2'h0, 16'ha5c3, 16'ha5c3},
        '{1'b1, 1'b1, 2'h0, 16'h1234, 16'h1234},
        '{1'b1, 1'b1, 2'h1, 16'h8001, 16'h8001},
        '{1'b1, 1'b1, 2'h2, 16'h7ffe, 16'h7ffe},
        '{1'b1, 1'b1, 2'h3, 16'hffff, 16'hffff},
        '{1'b1, 1'b0, 2'h0, 16'h0f0f, 16'hffff},
        '{1'b1, 1'b0, 2'h1, 16'h5a5a, 16'h0f0f},
        '{1'b1, 1'b0, 2'h2, 16'hc3c3, 16'h5a5a},
        '{1'b1, 1'b0, 2'h3, 16'h0001, 16'hc3c3}};
    int pmin[4] = '{30, 60, 120, 240};
    int pmax[4] = '{45, 90, 180, 360};
    int bmax[4] = '{2250, 3000, 4400, 7300};

    acrt_top #(.DATA_W(16)) dut (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .clk_en(clk_en),
        .pins(pins),
        .core_result(core_result),
        .busy(busy),
        .data_bus(data_bus),
        .data_bus_oe(data_bus_oe),
        .serial_port(serial_port)
    );

    acrt_host #(.DATA_W(16)) host (
        .ref_clk(ref_clk),
        .busy(busy),
        .data_bus(data_bus),
        .serial_port(serial_port),
        .pins(pins)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    initial
    begin
        #(40000 * 5);
        n_fail++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        n_fail = 0;
        total_checks = 0;
        sys_rst = 1'b1;
        clk_en = 1'b1;
        core_result = 16'h0000;
        repeat (16) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        foreach (rows[i])
        begin
            core_result = rows[i].res;
            host.convert(rows[i].sel, rows[i].rac, rows[i].div, 100000);
            `CHK(data_bus_oe, ~rows[i].sel)
            if (!rows[i].sel)
            begin
                `CHK(data_bus, rows[i].exp)
                `CHK(host.bfall > 0 && host.bfall <= 290, 1'b1)
                `CHK(host.dvalid > 0 && host.dvalid <= 282, 1'b1)
                `CHK(host.bfall - host.dvalid >= 4, 1'b1)
                `CHK(host.sync_at, -1)
            end
            else
            begin
                `CHK(host.word, rows[i].exp)
                `CHK(host.nclk, 16)
                `CHK((host.clk1 - host.sync_at) * 5 >= (rows[i].div == 2'h0 ? 3 : 20), 1'b1)
                `CHK((host.clk2 - host.clk1) * 5 >= pmin[rows[i].div], 1'b1)
                `CHK((host.clk2 - host.clk1) * 5 <= pmax[rows[i].div], 1'b1)
            end
            if (rows[i].sel && !rows[i].rac)
            begin
                `CHK(host.bfall > 0 && host.bfall <= 290, 1'b1)
                `CHK(host.sync_at * 5 >= 500 && host.sync_at * 5 <= 625, 1'b1)
                `CHK(host.sync_at < host.bfall, 1'b1)
            end
            if (rows[i].sel && rows[i].rac)
            begin
                `CHK(host.sync_at * 5 >= 1250 && host.sync_at * 5 <= 1375, 1'b1)
                `CHK(host.dvalid < host.sync_at, 1'b1)
                `CHK(host.bfall - host.sfall, 5)
                `CHK((host.bfall - host.brise) * 5 <= bmax[rows[i].div], 1'b1)
            end
        end
        // Abort a parallel conversion midway: no new word may appear.
        held = data_bus;
        core_result = 16'h3c3c;
        host.convert(1'b0, 1'b0, 2'h0, 60);
        `CHK(host.bfall > 0 && host.bfall <= 70, 1'b1)
        `CHK(data_bus, held)
        // The next conversion right after the abort still delivers its own word.
        host.convert(1'b0, 1'b0, 2'h0, 100000);
        `CHK(data_bus, 16'h3c3c)
        `CHK(host.bfall > 0 && host.bfall <= 290, 1'b1)
        // A low clock enable for 100 cycles stretches the conversion by exactly that much.
        core_result = 16'h9669;
        fork
            host.convert(1'b0, 1'b0, 2'h0, 100000);
            begin
                repeat (100) @(posedge ref_clk);
                #1;
                clk_en = 1'b0;
                repeat (100) @(posedge ref_clk);
                #1;
                clk_en = 1'b1;
            end
        join
        `CHK(host.bfall, 364)
        `CHK(host.dvalid, 360)
        `CHK(data_bus, 16'h9669)
        // Reset in the middle of a read-after-convert transfer clears busy, the data bus and the serial port.
        fork
            host.convert(1'b1, 1'b1, 2'h3, 100000);
            begin
                repeat (400) @(posedge ref_clk);
                #1;
                sys_rst = 1'b1;
                repeat (3) @(posedge ref_clk);
                #1;
                `CHK(busy, 1'b0)
                `CHK(data_bus, 16'h0000)
                `CHK(serial_port, 3'h0)
                sys_rst = 1'b0;
            end
        join
        // The first conversion after the reset runs normally.
        host.convert(1'b0, 1'b0, 2'h0, 100000);
        `CHK(data_bus, 16'h9669)
        `CHK(host.bfall, 264)
        `CHK(host.dvalid, 260)
        end_of_test();
    end
endmodule // acrt_top_tb

// ===== hdl/acrt_consts.svh
// Timing figures and reset values of the conversion and readout sequencer.
`ifndef ACRT_CONSTS_SVH
`define ACRT_CONSTS_SVH

`define ACRT_CLK_PERIOD_NS 5
`define ACRT_SYNC_LAT_CYC 3
`define ACRT_PINS_RST 6'h20

`define ACRT_T_RESULT_NS 1300
`define ACRT_T_DATA_MAX_NS 1410
`define ACRT_T_CONV_MAX_NS 1450
`define ACRT_T_DATA_TO_BUSY_NS 20
`define ACRT_T_RDC_SYNC_NS 560
`define ACRT_T_RAC_SYNC_NS 1310
`define ACRT_T_SYNC_TO_BUSY_NS 25
`define ACRT_T_SCLK_HALF0_NS 20
`define ACRT_T_FIRST_EDGE_NS 20
`define ACRT_T_RAC_BUSY0_NS 2250
`define ACRT_T_RAC_BUSY1_NS 3000
`define ACRT_T_RAC_BUSY2_NS 4400
`define ACRT_T_RAC_BUSY3_NS 7300

`define ACRT_CEIL_CYC(t) (((t) + `ACRT_CLK_PERIOD_NS - 1) / `ACRT_CLK_PERIOD_NS)
`define ACRT_FLOOR_CYC(t) ((t) / `ACRT_CLK_PERIOD_NS)
`define ACRT_RESULT_CYC (`ACRT_FLOOR_CYC(`ACRT_T_RESULT_NS) - `ACRT_SYNC_LAT_CYC)
`define ACRT_DATA_MAX_CYC (`ACRT_FLOOR_CYC(`ACRT_T_DATA_MAX_NS) - `ACRT_SYNC_LAT_CYC)
`define ACRT_CONV_MAX_CYC (`ACRT_FLOOR_CYC(`ACRT_T_CONV_MAX_NS) - `ACRT_SYNC_LAT_CYC)
`define ACRT_BUSY_CYC (`ACRT_RESULT_CYC + `ACRT_CEIL_CYC(`ACRT_T_DATA_TO_BUSY_NS))
`define ACRT_RDC_SYNC_CYC (`ACRT_FLOOR_CYC(`ACRT_T_RDC_SYNC_NS) - `ACRT_SYNC_LAT_CYC)
`define ACRT_RAC_SYNC_CYC (`ACRT_FLOOR_CYC(`ACRT_T_RAC_SYNC_NS) - `ACRT_SYNC_LAT_CYC)
`define ACRT_SYNC_TO_BUSY_CYC `ACRT_CEIL_CYC(`ACRT_T_SYNC_TO_BUSY_NS)
`define ACRT_SCLK_HALF0_CYC `ACRT_CEIL_CYC(`ACRT_T_SCLK_HALF0_NS)
`define ACRT_FIRST_EDGE_CYC `ACRT_CEIL_CYC(`ACRT_T_FIRST_EDGE_NS)
`define ACRT_RAC_BUSY_MAX_CYC(t) (`ACRT_FLOOR_CYC(t) - `ACRT_SYNC_LAT_CYC)

`endif

// ===== hdl/acrt_pkg.sv
// Types shared by the conversion and readout sequencer.
package acrt_pkg;

    typedef struct packed {
        logic convert_start_n;
        logic serial_parallel_select;
        logic read_after_convert;
        logic conversion_reset;
        logic [1:0] serial_clock_divider;
    } acrt_pins_t;

    typedef struct packed {
        logic frame_sync;
        logic serial_data_clock;
        logic serial_data_out;
    } acrt_serial_t;

    typedef enum logic [2:0] {
        ACRT_CV_IDLE = 3'b001,
        ACRT_CV_RUN = 3'b010,
        ACRT_CV_HOLD = 3'b100
    } acrt_conv_state_t;

    typedef enum logic [3:0] {
        ACRT_SR_IDLE = 4'b0001,
        ACRT_SR_LEAD = 4'b0010,
        ACRT_SR_SHIFT = 4'b0100,
        ACRT_SR_TAIL = 4'b1000
    } acrt_ser_state_t;

endpackage

// ===== hdl/acrt_sync.sv
// Two-stage synchroniser for a group of asynchronous pin levels.
`timescale 1ns/100ps
module acrt_sync #(
    parameter int W = 6,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock, reset and enable.
    input wire logic clk,
    input wire logic rst,
    input wire logic en,
    // Levels.
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_q <= RST_VAL;
            q <= RST_VAL;
        end
        else if (en)
        begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // acrt_sync

// ===== hdl/acrt_top.sv
// Conversion sequencer with parallel and master serial result readout.
// Function
// [R01] Busy ends within 1.45 us outside read-after-convert.
// [R02] Parallel result valid by 1.41 us after start.
// [R03] Result valid 20 ns before busy falls.
// [R04] Read-during-convert frame sync about 560 ns.
// [R05] Read-after-convert frame sync about 1.31 us.
// [R06] Read-after-convert busy spans transfer, bounded per divider.
// [R07] Busy falls about 25 ns after frame sync.
// [R08] First serial clock edge delayed after frame sync.
// [R09] Serial clock period scales with divider setting.
// [R10] Controller spaces starts; starts while busy ignored.
// [R11] Select low parallel, high serial modes.
// [R12] Result available at conversion end, no latency.
`timescale 1ns/100ps
`include "acrt_consts.svh"
module acrt_top #(
    parameter int DATA_W = 16
) (
    // Clock, reset and enable.
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Asynchronous control pins.
    input wire acrt_pkg::acrt_pins_t pins,
    // Result word from the converter core.
    input wire logic [DATA_W-1:0] core_result,
    // Status and parallel port.
    output logic busy,
    output logic [DATA_W-1:0] data_bus,
    output logic data_bus_oe,
    // Master serial port.
    output acrt_pkg::acrt_serial_t serial_port
);
    import acrt_pkg::*;

    localparam int BW = $clog2(DATA_W);

    if (DATA_W < 2 || DATA_W > 32)
    begin : g_bad_width
        $error("DATA_W must lie between 2 and 32.");
    end
    if (`ACRT_RESULT_CYC > `ACRT_DATA_MAX_CYC || `ACRT_BUSY_CYC > `ACRT_CONV_MAX_CYC
        || `ACRT_RAC_SYNC_CYC <= `ACRT_RESULT_CYC)
    begin : g_bad_timing
        $error("Conversion timing counts are inconsistent.");
    end

    ////////////////////////////////////////////////////////////////////////////
    acrt_pins_t pin_s;
    logic start_n_prev_q;
    logic start_edge;
    logic abort;

    acrt_sync #(
        .W($bits(acrt_pins_t)),
        .RST_VAL(`ACRT_PINS_RST)
    ) u_pin_sync (
        .clk(ref_clk),
        .rst(sys_rst),
        .en(clk_en),
        .d(pins),
        .q(pin_s)
    );

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            start_n_prev_q <= 1'b1;
        else if (clk_en)
            start_n_prev_q <= pin_s.convert_start_n;
    end

    assign start_edge = clk_en && start_n_prev_q && !pin_s.convert_start_n;
    assign abort = pin_s.conversion_reset;

    ////////////////////////////////////////////////////////////////////////////
    acrt_conv_state_t conv_q;
    acrt_ser_state_t sr_q;
    logic [10:0] conv_cnt_q;
    logic rac_q;
    logic ser_q;
    logic [1:0] div_q;
    logic [DATA_W-1:0] data_q;
    logic result_ok_q;
    logic [2:0] gap_q;
    logic ser_done;

    // A start edge is taken only while idle; the controller keeps the spacing.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            conv_q <= ACRT_CV_IDLE;
        else if (clk_en)
        begin
            if (abort)
                conv_q <= ACRT_CV_IDLE;
            else
            begin
                unique case (conv_q)
                    ACRT_CV_IDLE:
                        if (start_edge)
                            conv_q <= ACRT_CV_RUN; // [R10]
                    ACRT_CV_RUN:
                        if (conv_cnt_q == 11'(`ACRT_BUSY_CYC))
                            conv_q <= (rac_q && ser_q) ? ACRT_CV_HOLD : ACRT_CV_IDLE; // [R01] [R06]
                    ACRT_CV_HOLD:
                        if (gap_q == 3'h1)
                            conv_q <= ACRT_CV_IDLE; // [R07]
                    default:
                        conv_q <= ACRT_CV_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            conv_cnt_q <= 11'h000;
        else if (clk_en)
        begin
            if (abort || (conv_q == ACRT_CV_IDLE && !start_edge))
                conv_cnt_q <= 11'h000;
            else if (conv_q == ACRT_CV_IDLE)
                conv_cnt_q <= 11'h001;
            else
                conv_cnt_q <= conv_cnt_q + 11'h001;
        end
    end

    // Mode pins are captured once per conversion.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            rac_q <= 1'b0;
            ser_q <= 1'b0;
            div_q <= 2'h0;
        end
        else if (start_edge && conv_q == ACRT_CV_IDLE)
        begin
            rac_q <= pin_s.read_after_convert;
            ser_q <= pin_s.serial_parallel_select; // [R11]
            div_q <= pin_s.serial_clock_divider;
        end
    end

    // The result is latched as the conversion ends, at least four cycles before busy drops.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            data_q <= '0;
            result_ok_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (abort || (start_edge && conv_q == ACRT_CV_IDLE))
                result_ok_q <= 1'b0;
            else if (conv_q == ACRT_CV_RUN && conv_cnt_q == 11'(`ACRT_RESULT_CYC))
            begin
                data_q <= core_result; // [R02] [R12]
                result_ok_q <= 1'b1; // [R03]
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            gap_q <= 3'h0;
        else if (clk_en)
        begin
            if (abort)
                gap_q <= 3'h0;
            else if (ser_done && conv_q == ACRT_CV_HOLD)
                gap_q <= 3'(`ACRT_SYNC_TO_BUSY_CYC); // [R07]
            else if (gap_q != 3'h0)
                gap_q <= gap_q - 3'h1;
        end
    end

    assign busy = (conv_q != ACRT_CV_IDLE);
    assign data_bus = data_q;
    assign data_bus_oe = !pin_s.serial_parallel_select; // [R11]

    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] half_q;
    logic [7:0] half_cyc;
    logic half_hit;
    logic [BW-1:0] bit_q;
    logic [DATA_W-1:0] shreg_q;
    logic sync_q;
    logic sclk_q;
    logic sdo_q;
    logic ser_start;

    assign half_cyc = 8'(`ACRT_SCLK_HALF0_CYC) << div_q; // [R09]
    assign half_hit = (half_q == 8'h01);
    assign ser_start = clk_en && !abort && conv_q == ACRT_CV_RUN && ser_q && sr_q == ACRT_SR_IDLE
        && conv_cnt_q == (rac_q ? 11'(`ACRT_RAC_SYNC_CYC) : 11'(`ACRT_RDC_SYNC_CYC)); // [R04] [R05]
    assign ser_done = clk_en && sr_q == ACRT_SR_TAIL && half_hit;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            sr_q <= ACRT_SR_IDLE;
        else if (clk_en)
        begin
            if (abort)
                sr_q <= ACRT_SR_IDLE;
            else
            begin
                unique case (sr_q)
                    ACRT_SR_IDLE:
                        if (ser_start)
                            sr_q <= ACRT_SR_LEAD;
                    ACRT_SR_LEAD:
                        if (half_hit)
                            sr_q <= ACRT_SR_SHIFT; // [R08]
                    ACRT_SR_SHIFT:
                        if (half_hit && sclk_q && bit_q == BW'(DATA_W - 1))
                            sr_q <= ACRT_SR_TAIL;
                    ACRT_SR_TAIL:
                        if (half_hit)
                            sr_q <= ACRT_SR_IDLE;
                    default:
                        sr_q <= ACRT_SR_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            half_q <= 8'h00;
        else if (clk_en)
        begin
            if (ser_start || (sr_q != ACRT_SR_IDLE && half_hit))
                half_q <= half_cyc; // [R08] [R09]
            else if (sr_q != ACRT_SR_IDLE)
                half_q <= half_q - 8'h01;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            sync_q <= 1'b0;
            sclk_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (abort)
            begin
                sync_q <= 1'b0;
                sclk_q <= 1'b0;
            end
            else
            begin
                if (ser_start)
                    sync_q <= 1'b1;
                else if (ser_done)
                    sync_q <= 1'b0;
                if ((sr_q == ACRT_SR_LEAD || sr_q == ACRT_SR_SHIFT) && half_hit)
                    sclk_q <= ~sclk_q; // [R09]
            end
        end
    end

    // Data leaves MSB first and changes on the falling serial clock edge.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            shreg_q <= '0;
            sdo_q <= 1'b0;
            bit_q <= '0;
        end
        else if (clk_en)
        begin
            if (ser_start)
            begin
                shreg_q <= data_q;
                sdo_q <= data_q[DATA_W-1];
                bit_q <= '0;
            end
            else if (sr_q == ACRT_SR_SHIFT && half_hit && sclk_q && bit_q != BW'(DATA_W - 1))
            begin
                shreg_q <= {shreg_q[DATA_W-2:0], 1'b0};
                sdo_q <= shreg_q[DATA_W-2];
                bit_q <= bit_q + 1'b1;
            end
        end
    end

    assign serial_port = '{frame_sync: sync_q, serial_data_clock: sclk_q, serial_data_out: sdo_q};

    ////////////////////////////////////////////////////////////////////////////
    localparam int CONV_MAX = `ACRT_CONV_MAX_CYC;
    localparam int RDC_SYNC = `ACRT_RDC_SYNC_CYC;
    localparam int RAC_SYNC = `ACRT_RAC_SYNC_CYC;
    int rac_busy_max;

    always_comb
    begin
        unique case (div_q)
            2'h0: rac_busy_max = `ACRT_RAC_BUSY_MAX_CYC(`ACRT_T_RAC_BUSY0_NS);
            2'h1: rac_busy_max = `ACRT_RAC_BUSY_MAX_CYC(`ACRT_T_RAC_BUSY1_NS);
            2'h2: rac_busy_max = `ACRT_RAC_BUSY_MAX_CYC(`ACRT_T_RAC_BUSY2_NS);
            2'h3: rac_busy_max = `ACRT_RAC_BUSY_MAX_CYC(`ACRT_T_RAC_BUSY3_NS);
        endcase
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst || !clk_en);

    property p_busy_max;
        busy && !(rac_q && ser_q) |-> int'(conv_cnt_q) <= CONV_MAX;
    endproperty
    a_busy_max: assert property (p_busy_max) else $error("Busy too long."); // [R01]

    property p_data_latch;
        conv_q == ACRT_CV_RUN && conv_cnt_q == 11'(`ACRT_RESULT_CYC) |=> data_bus == $past(core_result);
    endproperty
    a_data_latch: assert property (p_data_latch) else $error("Result not presented in time."); // [R02]

    property p_data_lead;
        $fell(busy) && !$past(abort) |-> $past(result_ok_q, 4);
    endproperty
    a_data_lead: assert property (p_data_lead) else $error("Result valid too late before busy fell."); // [R03]

    property p_rdc_sync;
        $rose(sync_q) && !rac_q |-> int'(conv_cnt_q) == RDC_SYNC + 1 && busy;
    endproperty
    a_rdc_sync: assert property (p_rdc_sync) else $error("Read-during frame sync misplaced."); // [R04]

    property p_rac_sync;
        $rose(sync_q) && rac_q |-> int'(conv_cnt_q) == RAC_SYNC + 1 && result_ok_q;
    endproperty
    a_rac_sync: assert property (p_rac_sync) else $error("Read-after frame sync misplaced."); // [R05]

    property p_rac_busy;
        busy && rac_q && ser_q |-> int'(conv_cnt_q) <= rac_busy_max;
    endproperty
    a_rac_busy: assert property (p_rac_busy) else $error("Read-after busy too long."); // [R06]

    property p_sync_to_busy;
        $fell(sync_q) && conv_q == ACRT_CV_HOLD |-> busy [*5] ##1 !busy;
    endproperty
    a_sync_to_busy: assert property (p_sync_to_busy) else $error("Busy fall not 25 ns after sync."); // [R07]

    property p_first_edge;
        $rose(sync_q) |-> !sclk_q [*4];
    endproperty
    a_first_edge: assert property (p_first_edge) else $error("First serial clock edge too early."); // [R08]

    property p_sclk_high;
        $rose(sclk_q) |-> sclk_q [*4] ##0 (half_q <= half_cyc);
    endproperty
    a_sclk_high: assert property (p_sclk_high) else $error("Serial clock high too short."); // [R09]

    property p_par_quiet;
        $rose(sync_q) |-> ser_q;
    endproperty
    a_par_quiet: assert property (p_par_quiet) else $error("Serial transfer in parallel mode."); // [R11]

    property p_no_latency;
        conv_q == ACRT_CV_RUN && !abort ##1 conv_q != ACRT_CV_RUN |-> result_ok_q;
    endproperty
    a_no_latency: assert property (p_no_latency) else $error("Conversion ended without a result."); // [R12]

    c_parallel: cover property ($fell(busy) && !ser_q);
    c_rdc: cover property ($fell(sync_q) && !rac_q);
    c_rac_slow: cover property ($fell(busy) && rac_q && ser_q && div_q == 2'h3);
    c_abort: cover property (abort && busy);
endmodule // acrt_top
